/* File: src/cycle_timer.sv */
`timescale 1ns/1ns
module cycle_timer #(
  parameter int W = 10
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic         abort,
  input  wire logic [W-1:0] load,
  output logic              busy,
  output logic              done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_s;

  tmr_s cur;
  tmr_s next_cur;

  if (W < 2) begin : g_chk
    $error("cycle_timer needs W >= 2");
  end

  // ==========================================================
  // Down counter; done marks the last counted cycle
  always_comb begin
    next_cur = cur;
    if (abort) begin
      next_cur.cnt = '0;
    end else if (start) begin
      next_cur.cnt = load;
    end else if (cur.cnt != '0) begin
      next_cur.cnt = cur.cnt - W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign busy = (cur.cnt != '0);
  assign done = (cur.cnt == W'(1)) && !abort;
endmodule : cycle_timer

/* File: src/fault_cfg_pkg.sv */
package fault_cfg_pkg;

  // ==========================================================
  // Command codes and reset values
  localparam logic [7:0]  CMD_UV_WARN     = 8'h43;
  localparam logic [7:0]  CMD_UV_ACTION   = 8'h45;
  localparam logic [7:0]  CMD_OC_LIMIT    = 8'h46;
  localparam logic [15:0] RST_UV_WARN     = 16'h0067;
  localparam logic [7:0]  RST_UV_ACTION   = 8'h40;
  localparam logic [15:0] RST_OC_LIMIT    = 16'h0019;

  // ==========================================================
  // Response byte fields
  localparam int          MODE_HI         = 7;
  localparam int          MODE_LO         = 6;
  localparam int          RETRY_HI        = 5;
  localparam int          RETRY_LO        = 3;
  localparam int          DSEL_HI         = 1;
  localparam int          DSEL_LO         = 0;
  localparam logic [1:0]  MODE_CONTINUE   = 2'h0;
  localparam logic [1:0]  MODE_DELAY      = 2'h1;
  localparam logic [2:0]  RETRY_LATCH     = 3'h0;
  localparam logic [2:0]  RETRY_HICCUP    = 3'h7;

  // ==========================================================
  // Peak current limit layout (exponent 15:11, mantissa 10:0)
  localparam int          OC_EXP_HI       = 15;
  localparam int          OC_EXP_LO       = 11;
  localparam logic [4:0]  OC_EXP_FIXED    = 5'h00;
  localparam logic [10:0] OC_MIN          = 11'h001;
  localparam logic [10:0] OC_MAX          = 11'h01f;

  // ==========================================================
  // Status flag and percent config bit positions
  localparam int          FLAG_UV_WARN    = 6;
  localparam int          FLAG_UV_FAULT   = 4;
  localparam int          PCT_UV_HI       = 5;
  localparam int          PCT_UV_LO       = 3;

  // ==========================================================
  // Timing
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          DELAY0_NS       = 6250;
  localparam int          DELAY1_NS       = 7500;
  localparam int          DELAY2_NS       = 8750;
  localparam int          DELAY3_NS       = 10000;
  localparam int          DLY_W           = 10;
  localparam logic [DLY_W-1:0] DELAY0_CYC = DLY_W'((DELAY0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] DELAY1_CYC = DLY_W'((DELAY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] DELAY2_CYC = DLY_W'((DELAY2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] DELAY3_CYC = DLY_W'((DELAY3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          HICCUP_MS       = 1000;
  localparam int          HIC_W           = 27;
  localparam longint      HICCUP_CYC      = longint'(HICCUP_MS) * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {RSP_IDLE, RSP_DELAY, RSP_LATCHED, RSP_HICCUP} rsp_state_e;

endpackage : fault_cfg_pkg

/* File: src/output_fault_limit_config.sv */
// How it works
// RL1: Warning threshold is a 16-bit linear value, resets to 0067 hex.
// RL2: Output below warning threshold sets bit 6 of output voltage flags.
// RL3: Fault comparator uses threshold selected by percent config bits 5:3.
// RL4: Under-voltage fault sets summary bit, fault flag and pulls alert low.
// RL5: Fault flags stay set until clear-faults, never self-clear.
// RL6: Fault action register is eight bits, resets to 40 hex (latch off).
// RL7: Mode 00 keeps running through an under-voltage fault.
// RL8: Mode 01 waits the selected delay, then retries only if fault remains.
// RL9: Delay codes give 6.25, 7.5, 8.75 or 10 us; bit 2 ignored.
// RL10: Unsupported mode or retry codes are refused and flag invalid data.
// RL11: Retry 000 keeps output disabled until faults are cleared.
// RL12: Retry 111 restarts every 1 s without limit.
// RL13: Hiccup stops on enable off, input power loss or another shutdown fault.
// RL14: Peak current limit is LINEAR11, applied to high-side current.
// RL15: Peak current limit resets to 0019 hex, 25 A.
// RL16: Exponent is read-only; a different written exponent flags invalid data.
// RL17: Only limit codes 0001 to 001F are accepted, one ampere per step.
// RL18: High-side current above the limit raises a peak over-current fault.
// RL19: Store command copies the three registers to nonvolatile storage.
// RL20: A refused write leaves the register unchanged.
`timescale 1ns/1ns
module output_fault_limit_config
  import fault_cfg_pkg::*;
#(
  parameter longint HICCUP_CYCLES = fault_cfg_pkg::HICCUP_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  input  wire logic        store_stb,
  output logic             nvm_wr,
  output logic      [39:0] nvm_data,
  input  wire logic        clear_faults,
  input  wire logic [15:0] percent_threshold_config,
  output logic      [2:0]  uv_threshold_sel,
  input  wire logic [15:0] vout_code,
  input  wire logic [10:0] hs_current,
  input  wire logic        uv_fault_pin,
  input  wire logic        enable_pin,
  input  wire logic        vin_good_pin,
  input  wire logic        other_shutdown,
  output logic      [7:0]  output_voltage_flags,
  output logic             status_word_vout,
  output logic             oc_peak_fault,
  output logic             invalid_data_fault,
  output logic             output_enable,
  output logic             alert_line_n_out,
  output logic             alert_line_n_oe
);
  import fault_cfg_pkg::*;

  if (HICCUP_CYCLES < 2 || HICCUP_CYCLES >= (longint'(1) << HIC_W)) begin : g_chk
    $error("HICCUP_CYCLES out of range for the hiccup timer");
  end

  typedef struct packed {
    logic [15:0] warn_thr;
    logic [7:0]  action;
    logic [15:0] oc_thr;
    logic [7:0]  vflags;
    logic        summary;
    logic        invalid;
    logic        oc_fault;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        nvm_wr;
    logic [39:0] nvm_data;
    logic [2:0]  uv_sel;
    logic        out_en;
    rsp_state_e  st;
    logic [DLY_W-1:0] dly_age;
  } state_s;

  localparam state_s RESET_STATE = '{
    warn_thr: RST_UV_WARN,
    action:   RST_UV_ACTION,
    oc_thr:   RST_OC_LIMIT,
    vflags:   8'h00,
    summary:  1'b0,
    invalid:  1'b0,
    oc_fault: 1'b0,
    rd_data:  16'h0000,
    rd_valid: 1'b0,
    nvm_wr:   1'b0,
    nvm_data: 40'h00_0000_0000,
    uv_sel:   3'h0,
    out_en:   1'b1,
    st:       RSP_IDLE,
    dly_age:  '0
  };

  state_s                cur;
  state_s                next_cur;
  logic   [2:0]          pins_s;
  logic                  uv_s;
  logic                  en_s;
  logic                  vin_s;
  logic                  stop_hiccup;
  logic                  action_ok;
  logic                  oc_ok;
  logic   [DLY_W-1:0]    dly_load;
  logic                  dly_start;
  logic                  dly_done;
  logic                  hic_start;
  logic                  hic_abort;
  logic                  hic_done;

  // ==========================================================
  // Pin inputs
  pin_sync #(.W(3)) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({uv_fault_pin, enable_pin, vin_good_pin}),
    .sync_out (pins_s)
  );
  assign uv_s  = pins_s[2];
  assign en_s  = pins_s[1];
  assign vin_s = pins_s[0];
  assign stop_hiccup = !en_s || !vin_s || other_shutdown;   // [RL13]

  // ==========================================================
  // Write checks
  assign action_ok = (wr_data[MODE_HI:MODE_LO] == MODE_CONTINUE || wr_data[MODE_HI:MODE_LO] == MODE_DELAY)
                  && (wr_data[RETRY_HI:RETRY_LO] == RETRY_LATCH || wr_data[RETRY_HI:RETRY_LO] == RETRY_HICCUP); // [RL10]
  assign oc_ok = (wr_data[OC_EXP_HI:OC_EXP_LO] == OC_EXP_FIXED)                                        // [RL16]
              && (wr_data[10:0] >= OC_MIN) && (wr_data[10:0] <= OC_MAX);                               // [RL17]

  // Bit 2 of the delay field has no effect
  always_comb begin
    case (cur.action[DSEL_HI:DSEL_LO])                                                                  // [RL9]
      2'h0:    dly_load = DELAY0_CYC;
      2'h1:    dly_load = DELAY1_CYC;
      2'h2:    dly_load = DELAY2_CYC;
      default: dly_load = DELAY3_CYC;
    endcase
  end

  // ==========================================================
  // Timers
  cycle_timer #(.W(DLY_W)) u_delay (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (dly_start),
    .abort   (1'b0),
    .load    (dly_load),
    .busy    (),
    .done    (dly_done)
  );

  cycle_timer #(.W(HIC_W)) u_hiccup (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (hic_start),
    .abort   (hic_abort),
    .load    (HIC_W'(HICCUP_CYCLES)),                                                                   // [RL12]
    .busy    (),
    .done    (hic_done)
  );

  // ==========================================================
  // Next state
  always_comb begin
    next_cur  = cur;
    dly_start = 1'b0;
    hic_start = 1'b0;
    hic_abort = 1'b0;
    next_cur.rd_valid = 1'b0;
    next_cur.nvm_wr   = 1'b0;
    next_cur.uv_sel   = percent_threshold_config[PCT_UV_HI:PCT_UV_LO];                               // [RL3]
    // Cycles spent in the current delay run; only the checks read it
    next_cur.dly_age  = (cur.st == RSP_DELAY) ? cur.dly_age + DLY_W'(1) : '0;

    // Writes; a refused value keeps the old contents
    if (wr_stb) begin
      case (cmd_code)
        CMD_UV_WARN: begin
          next_cur.warn_thr = wr_data;                                                                  // [RL1]
        end
        CMD_UV_ACTION: begin
          if (action_ok) begin
            next_cur.action = wr_data[7:0];                                                             // [RL6]
          end
        end
        CMD_OC_LIMIT: begin
          if (oc_ok) begin
            next_cur.oc_thr = wr_data;                                                                  // [RL14]
          end
        end
        default: begin
        end
      endcase
    end

    if (rd_stb) begin
      next_cur.rd_valid = 1'b1;
      case (cmd_code)
        CMD_UV_WARN:   next_cur.rd_data = cur.warn_thr;
        CMD_UV_ACTION: next_cur.rd_data = {8'h00, cur.action};
        CMD_OC_LIMIT:  next_cur.rd_data = cur.oc_thr;
        default:       next_cur.rd_data = 16'h0000;
      endcase
    end

    if (store_stb) begin
      next_cur.nvm_wr   = 1'b1;
      next_cur.nvm_data = {cur.warn_thr, cur.action, cur.oc_thr};                                     // [RL19]
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    next_cur.invalid = (cur.invalid && !clear_faults)
                    || (wr_stb && cmd_code == CMD_UV_ACTION && !action_ok)                              // [RL10]
                    || (wr_stb && cmd_code == CMD_OC_LIMIT && !oc_ok);                                  // [RL20]
    next_cur.vflags = cur.vflags & ~{8{clear_faults}};                                                  // [RL5]
    if (vout_code < cur.warn_thr) begin
      next_cur.vflags[FLAG_UV_WARN] = 1'b1;                                                             // [RL2]
    end
    if (uv_s) begin
      next_cur.vflags[FLAG_UV_FAULT] = 1'b1;                                                            // [RL4]
    end
    next_cur.summary  = (cur.summary && !clear_faults) || uv_s || (vout_code < cur.warn_thr);          // [RL4]
    next_cur.oc_fault = (cur.oc_fault && !clear_faults) || (hs_current > cur.oc_thr[10:0]);            // [RL18]

    // Fault response sequence
    case (cur.st)
      RSP_IDLE: begin
        if (uv_s && cur.action[MODE_HI:MODE_LO] == MODE_DELAY) begin                                    // [RL7]
          dly_start   = 1'b1;
          next_cur.st = RSP_DELAY;                                                                      // [RL8]
        end
      end
      RSP_DELAY: begin
        if (dly_done) begin
          if (!uv_s) begin
            next_cur.st = RSP_IDLE;                                                                     // [RL8]
          end else if (cur.action[RETRY_HI:RETRY_LO] == RETRY_HICCUP) begin
            hic_start       = 1'b1;
            next_cur.out_en = 1'b0;
            next_cur.st     = RSP_HICCUP;                                                               // [RL12]
          end else begin
            next_cur.out_en = 1'b0;
            next_cur.st     = RSP_LATCHED;                                                              // [RL11]
          end
        end
      end
      RSP_LATCHED: begin
        if (clear_faults) begin
          next_cur.out_en = 1'b1;
          next_cur.st     = RSP_IDLE;                                                                   // [RL11]
        end
      end
      RSP_HICCUP: begin
        if (stop_hiccup) begin
          hic_abort       = 1'b1;
          next_cur.out_en = 1'b1;
          next_cur.st     = RSP_IDLE;                                                                   // [RL13]
        end else if (hic_done) begin
          next_cur.out_en = 1'b1;
          next_cur.st     = RSP_IDLE;                                                                   // [RL12]
        end
      end
      default: begin
        next_cur.st = RSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur <= RESET_STATE;                                                                               // [RL15]
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================
  // Outputs
  assign rd_data              = cur.rd_data;
  assign rd_valid             = cur.rd_valid;
  assign nvm_wr               = cur.nvm_wr;
  assign nvm_data             = cur.nvm_data;
  assign uv_threshold_sel     = cur.uv_sel;
  assign output_voltage_flags = cur.vflags;
  assign status_word_vout     = cur.summary;
  assign oc_peak_fault        = cur.oc_fault;
  assign invalid_data_fault   = cur.invalid;
  assign output_enable        = cur.out_en;
  // Open-drain alert: drive low while any flag stands
  assign alert_line_n_out     = 1'b0;
  assign alert_line_n_oe      = (|cur.vflags) || cur.oc_fault || cur.invalid;                         // [RL4]

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  bad_action_kept_a: assert property (wr_stb && cmd_code == CMD_UV_ACTION && !action_ok |=> // [RL10] [RL20]
      cur.action == $past(cur.action) && invalid_data_fault) else $error("bad action write not refused");
  oc_code_range_a: assert property (cur.oc_thr[OC_EXP_HI:OC_EXP_LO] == OC_EXP_FIXED && // [RL16] [RL17]
      cur.oc_thr[10:0] >= OC_MIN && cur.oc_thr[10:0] <= OC_MAX) else $error("peak limit holds bad code");
  warn_flag_set_a: assert property (vout_code < cur.warn_thr |=> output_voltage_flags[FLAG_UV_WARN]) // [RL2]
    else $error("warning flag not set");
  uv_flags_set_a: assert property (uv_s |=> output_voltage_flags[FLAG_UV_FAULT] && status_word_vout // [RL4]
      && alert_line_n_oe) else $error("fault flags or alert missing");
  flag_sticky_a: assert property (output_voltage_flags[FLAG_UV_FAULT] && !clear_faults |=> // [RL5]
      output_voltage_flags[FLAG_UV_FAULT]) else $error("fault flag dropped without clear");
  continue_mode_a: assert property (cur.st == RSP_IDLE && cur.action[MODE_HI:MODE_LO] == MODE_CONTINUE // [RL7]
      |=> cur.st == RSP_IDLE && output_enable) else $error("mode 00 interrupted output");
  delay_hold_a: assert property (cur.st == RSP_IDLE && uv_s && cur.action[MODE_HI:MODE_LO] == MODE_DELAY // [RL8]
      |=> (cur.st == RSP_DELAY && output_enable)[*8]) else $error("delay not honoured");
  // Delay length is judged on dly_age so no long sequence has to be unrolled
  delay_len_a: assert property (cur.st == RSP_DELAY && cur.action[DSEL_HI:DSEL_LO] == 2'h0 // [RL9]
      |=> (cur.st == RSP_DELAY) == ($past(cur.dly_age) < DELAY0_CYC - DLY_W'(1)))
    else $error("shortest delay not 625 cycles");
  delay_max_a: assert property (cur.st == RSP_DELAY |-> cur.dly_age < DELAY3_CYC) // [RL9]
    else $error("delay longer than longest code");
  latch_off_a: assert property (cur.st == RSP_LATCHED && !clear_faults |=> !output_enable // [RL11]
      && cur.st == RSP_LATCHED) else $error("latched output came back");
  hiccup_entry_a: assert property (cur.st == RSP_DELAY && dly_done && uv_s // [RL12]
      && cur.action[RETRY_HI:RETRY_LO] == RETRY_HICCUP |=> cur.st == RSP_HICCUP && !output_enable)
    else $error("hiccup not entered");
  hiccup_stop_a: assert property (cur.st == RSP_HICCUP && stop_hiccup |=> cur.st == RSP_IDLE) // [RL13]
    else $error("hiccup did not stop");
  oc_detect_a: assert property (hs_current > cur.oc_thr[10:0] |=> oc_peak_fault) // [RL18]
    else $error("peak over-current missed");
  store_copy_a: assert property (store_stb |=> nvm_wr && nvm_data == // [RL19]
      {$past(cur.warn_thr), $past(cur.action), $past(cur.oc_thr)}) else $error("store copy wrong");
  sel_follow_a: assert property (1'b1 |=> uv_threshold_sel == $past(percent_threshold_config[PCT_UV_HI:PCT_UV_LO])) // [RL3]
    else $error("threshold select stale");

  hiccup_seen_c: cover property (cur.st == RSP_HICCUP ##1 cur.st == RSP_IDLE);
  latch_seen_c: cover property (cur.st == RSP_LATCHED ##1 clear_faults);
  refused_seen_c: cover property (wr_stb && cmd_code == CMD_OC_LIMIT && !oc_ok);
  store_seen_c: cover property (store_stb);
  delay_seen_c: cover property (cur.st == RSP_DELAY ##1 cur.st == RSP_IDLE);
endmodule : output_fault_limit_config

/* File: src/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s cur;
  sync_s next_cur;

  if (W < 1) begin : g_chk
    $error("pin_sync needs W >= 1");
  end

  // ==========================================================
  // Two stages; only the second stage is visible
  always_comb begin
    next_cur.meta   = async_in;
    next_cur.stable = cur.meta;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign sync_out = cur.stable;
endmodule : pin_sync

/* File: verification/pmbus_host_model.sv */
`timescale 1ns/1ns
// ==========================================================
// Host side of the command port
module pmbus_host_model (
  input  wire logic        clk_sys,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic             store_stb,
  output logic             clear_faults,
  output logic      [7:0]  cmd_code,
  output logic      [15:0] wr_data
);
  initial begin
    {wr_stb, rd_stb, store_stb, clear_faults} = 4'h0;
    cmd_code = 8'h00;
    wr_data = 16'h0000;
  end

  // Released command and data lines show inverted values so stale data never reads as valid; the strobes drop to 0
  task automatic req(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    {wr_stb, rd_stb} = k;
    cmd_code = c;
    wr_data = d;
    @(posedge clk_sys);
    #1;
    {wr_stb, rd_stb} = 2'h0;
    cmd_code = ~c;
    wr_data = ~d;
  endtask : req

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    req(2'h2, c, d);
  endtask : wr

  task automatic rd(input logic [7:0] c, output logic v, output logic [15:0] q);
    req(2'h1, c, 16'h0000);
    v = rd_valid;
    q = rd_data;
  endtask : rd

  // Store-user-settings or clear-faults request, one cycle
  task automatic pulse(input logic st);
    @(posedge clk_sys);
    #1;
    if (st) store_stb = 1'b1;
    else clear_faults = 1'b1;
    @(posedge clk_sys);
    #1;
    {store_stb, clear_faults} = 2'h0;
  endtask : pulse
endmodule : pmbus_host_model

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import fault_cfg_pkg::*;
  logic clk_sys, rst, wr_stb, rd_stb, store_stb, clear_faults, rd_valid, nvm_wr;
  logic uv_fault_pin, enable_pin, vin_good_pin, other_shutdown, status_word_vout;
  logic oc_peak_fault, invalid_data_fault, output_enable, alert_line_n_out, alert_line_n_oe;
  logic [7:0]  cmd_code, output_voltage_flags;
  logic [15:0] wr_data, rd_data, percent_threshold_config, vout_code, q, d, sh_act, sh_oc;
  logic [39:0] nvm_data;
  logic [10:0] hs_current;
  logic [2:0]  uv_threshold_sel;
  logic        v, ok;
  int          n_errors, cmp_count, seed, i, j;
  int          dly[4] = '{625, 750, 875, 1000};
  logic [15:0] corner[10] = '{16'h80, 16'h0, 16'hc0, 16'h20, 16'h48, 16'h801, 16'h78, 16'h1f, 16'h07, 16'h1};

  output_fault_limit_config #(.HICCUP_CYCLES(20)) uut (.clk_sys(clk_sys), .rst(rst), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .cmd_code(cmd_code), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .store_stb(store_stb), .nvm_wr(nvm_wr), .nvm_data(nvm_data), .clear_faults(clear_faults),
    .percent_threshold_config(percent_threshold_config), .uv_threshold_sel(uv_threshold_sel),
    .vout_code(vout_code), .hs_current(hs_current), .uv_fault_pin(uv_fault_pin), .enable_pin(enable_pin),
    .vin_good_pin(vin_good_pin), .other_shutdown(other_shutdown), .output_voltage_flags(output_voltage_flags),
    .status_word_vout(status_word_vout), .oc_peak_fault(oc_peak_fault), .invalid_data_fault(invalid_data_fault),
    .output_enable(output_enable), .alert_line_n_out(alert_line_n_out), .alert_line_n_oe(alert_line_n_oe));

  pmbus_host_model host (.clk_sys(clk_sys), .rd_valid(rd_valid), .rd_data(rd_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .store_stb(store_stb), .clear_faults(clear_faults), .cmd_code(cmd_code), .wr_data(wr_data));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Checking helpers
  task automatic check(input logic [40:0] got, input logic [40:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : ticks

  task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
    host.rd(c, v, q);
    check({v, q}, {1'b1, e});
  endtask : rd_chk

  // Bounded wait for the regulator enable to reach a level
  task automatic wait_oe(input logic lvl, input int lim);
    int n;
    n = 0;
    while (output_enable !== lvl && n < lim) begin
      ticks(1);
      n++;
    end
    check(output_enable, lvl);
  endtask : wait_oe

  function automatic logic act_ok(input logic [15:0] x);
    return !x[7] && (x[5:3] == 3'h0 || x[5:3] == 3'h7);
  endfunction : act_ok

  task automatic close_out;
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  // Whole run is about 9k cycles; 60k, over six times that, is a hang
  initial begin
    #600000;
    n_errors++;
    close_out();
  end

  // ==========================================================
  // Scenarios
  initial begin
    {rst, uv_fault_pin, other_shutdown, enable_pin, vin_good_pin} = 5'h13;
    {vout_code, hs_current, percent_threshold_config} = {16'hffff, 27'h0};
    seed = 62;
    ticks(4);
    rst = 1'b0;
    rd_chk(CMD_UV_WARN, 16'h0067);
    rd_chk(CMD_UV_ACTION, 16'h0040);
    rd_chk(CMD_OC_LIMIT, 16'h0019);
    rd_chk(8'h50, 16'h0000);
    sh_act = 16'h0040;
    sh_oc = 16'h0019;
    for (i = 0; i < 40; i++) begin
      d = (i < 10) ? corner[i] : 16'($random(seed));
      if (i % 3 == 2) d = i[0] ? {5'h0, 6'h0, d[4:0]} : {8'h0, d[7], 1'b0, d[5:0]};
      ok = i[0] ? (d >= 16'h1 && d <= 16'h1f) : act_ok(d);
      host.pulse(1'b0);
      host.wr(i[0] ? CMD_OC_LIMIT : CMD_UV_ACTION, d);
      ticks(1);
      check(invalid_data_fault, !ok);
      if (ok && i[0]) sh_oc = d;
      if (ok && !i[0]) sh_act = {8'h0, d[7:0]};
      rd_chk(i[0] ? CMD_OC_LIMIT : CMD_UV_ACTION, i[0] ? sh_oc : sh_act);
    end
    host.wr(CMD_UV_WARN, 16'h1234);
    host.wr(CMD_UV_ACTION, 16'h0041);
    host.wr(CMD_OC_LIMIT, 16'h0005);
    host.pulse(1'b0);
    host.pulse(1'b1);
    check({nvm_wr, nvm_data}, {1'b1, 16'h1234, 8'h41, 16'h0005});
    hs_current = 11'd5;
    ticks(3);
    check({oc_peak_fault, alert_line_n_oe}, 2'h0);
    hs_current = 11'd6;
    ticks(2);
    check({oc_peak_fault, alert_line_n_oe, alert_line_n_out}, 3'h6);
    hs_current = 11'd0;
    vout_code = 16'h1233;
    ticks(3);
    check({oc_peak_fault, output_voltage_flags}, 9'h140);
    vout_code = 16'hffff;
    ticks(3);
    check(output_voltage_flags, 8'h40);
    host.pulse(1'b0);
    ticks(1);
    check({output_voltage_flags, alert_line_n_oe}, 9'h0);
    // Random levels around warn limit 1234 hex and peak limit 5 A
    for (i = 0; i < 8; i++) begin
      vout_code = 16'h1200 | (16'($random(seed)) & 16'h007f);
      hs_current = 11'($random(seed)) & 11'h00f;
      host.pulse(1'b0);
      check({status_word_vout, output_voltage_flags, oc_peak_fault},
            {vout_code < 16'h1234, 1'b0, vout_code < 16'h1234, 6'h0, hs_current > 11'd5});
    end
    {vout_code, hs_current} = {16'hffff, 11'h0};
    host.pulse(1'b0);
    for (i = 0; i < 4; i++) begin
      percent_threshold_config = 16'($random(seed));
      ticks(2);
      check(uv_threshold_sel, percent_threshold_config[5:3]);
    end
    // Latch-off after each delay code; bit 2 of the code set on odd steps
    for (i = 0; i < 4; i++) begin
      host.wr(CMD_UV_ACTION, 16'h0040 | 16'(i) | (16'(i & 1) << 2));
      uv_fault_pin = 1'b1;
      ticks(dly[i] - 2);
      check(output_enable, 1'b1);
      wait_oe(1'b0, 12);
      check({status_word_vout, output_voltage_flags[4], alert_line_n_oe}, 3'h7);
      ticks(60);
      check(output_enable, 1'b0);
      uv_fault_pin = 1'b0;
      ticks(3);
      check(status_word_vout, 1'b1);
      host.pulse(1'b0);
      ticks(1);
      check(output_enable, 1'b1);
    end
    host.wr(CMD_UV_ACTION, 16'h0000);
    uv_fault_pin = 1'b1;
    ticks(1100);
    check({output_enable, output_voltage_flags[4]}, 2'h3);
    host.wr(CMD_UV_ACTION, 16'h0043);
    uv_fault_pin = 1'b0;
    host.pulse(1'b0);
    uv_fault_pin = 1'b1;
    ticks(100);
    uv_fault_pin = 1'b0;
    ticks(1100);
    check(output_enable, 1'b1);
    host.wr(CMD_UV_ACTION, 16'h0078);
    uv_fault_pin = 1'b1;
    wait_oe(1'b0, 700);
    wait_oe(1'b1, 30);
    for (j = 0; j < 3; j++) begin
      wait_oe(1'b0, 700);
      {enable_pin, vin_good_pin, other_shutdown} = (j == 0) ? 3'h2 : (j == 1) ? 3'h4 : 3'h7;
      ticks(4);
      check(output_enable, 1'b1);
      {enable_pin, vin_good_pin, other_shutdown} = 3'h6;
    end
    uv_fault_pin = 1'b0;
    close_out();
  end
endmodule : tb_top
